// ### logic/lhpi_pkg.sv
/*
 * Shared constants and carrier types for the legacy host port block.
 * Assumes a single 200 MHz device clock and synchronous active-low reset.
 */
package lhpi_pkg;
    ////////////////////////////////////////////////////////////////////////
    // Port offsets on the two host address bits
    localparam logic [1:0] LHPI_PORT_DATA = 2'h0;    // Read data / write data
    localparam logic [1:0] LHPI_PORT_STATUS = 2'h1;  // Status / soft reset
    localparam logic [1:0] LHPI_PORT_DRIVE = 2'h2;   // Drive kind / command start
    localparam logic [1:0] LHPI_PORT_ENABLE = 2'h3;  // Not used / enable port
    // Status bit positions
    localparam int LHPI_ST_REQ = 0;
    localparam int LHPI_ST_DIR = 1;
    localparam int LHPI_ST_CD = 2;
    localparam int LHPI_ST_BUSY = 3;
    localparam int LHPI_ST_DMA = 4;
    localparam int LHPI_ST_INT = 5;
    // Enable port bit positions
    localparam int LHPI_EN_DMA = 0;
    localparam int LHPI_EN_INT = 1;
    localparam int LHPI_EN_DRV = 2;
    // Local flavor select bit position in local register 58H
    localparam logic [7:0] LHPI_LOCAL_FLAVOR_REG = 8'h58;
    localparam int LHPI_FLAVOR_BIT = 7;
    // Reset values
    localparam logic [7:0] LHPI_RST_BYTE = 8'h00;
    localparam logic [2:0] LHPI_RST_EN = 3'h0;

    // Controller phases, coded onto command/data and direction bits
    typedef enum logic [1:0] {
        LHPI_PH_DATA_IN,
        LHPI_PH_DATA_OUT,
        LHPI_PH_COMMAND,
        LHPI_PH_STATUS
    } lhpi_phase_e;

    // Host bus strobes after synchronisation
    typedef struct packed {
        logic dack_n;
        logic sel_n;
        logic ior_n;
        logic iow_n;
        logic [1:0] addr;
        logic [7:0] wdata;
    } lhpi_host_s;

    // Local controller sequencing commands
    typedef struct packed {
        logic set_phase;          // Load a new phase while busy
        lhpi_phase_e phase;       // Phase to load
        logic byte_valid;         // A byte is offered or wanted
        logic [7:0] byte_data;    // Byte for the host to read
        logic finish;             // End of command
    } lhpi_seq_s;
endpackage

// ### logic/lhpi_sync.sv
/*
 * Two-flop synchroniser bank for host pins.
 * Assumes asynchronous pin inputs; output is delayed by two clocks.
 */
`timescale 1ns/100ps
module lhpi_sync #(
    parameter int W = 14
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    input wire logic [W-1:0] rst_val,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } lhpi_sync_s;
    lhpi_sync_s st;
    lhpi_sync_s next_st;

    ////////////////////////////////////////////////////////////////////////
    // First stage feeds only the second stage
    always_comb begin
        next_st.s1 = d;
        next_st.s2 = st.s1;
    end

    // Register both stages; idle value is held in the reset constant
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st <= {rst_val, rst_val};
        end else begin
            st <= next_st;
        end
    end

    // Second stage is the only output
    assign q = st.s2;
endmodule

// ### logic/lhpi_top.sv
/*
 * Host port logic: decodes host reads and writes onto data, status,
 * soft reset, drive kind, command start and enable ports, and builds
 * byte request, busy, phase, DMA request and interrupt status.
 * Assumes host strobes are asynchronous pins; local side is on clock.
 */
`timescale 1ns/100ps
// Functional notes
// - Respond only when flavor select bit set
// - DMA acknowledge forces data port access
// - DMA data on acknowledge in any phase; request only in data phase
// - Status top two bits read zero
// - Interrupt set at completion if enabled
// - Interrupt clears only by enable cleared
// - DMA request needs data phase, request, enable
// - One DMA request per byte, acknowledge clears
// - Busy from selection to end; block commands
// - Byte request toggles for every byte
// - Phase bits encode command, data, status
// - Completion status byte readable on data port
// - Soft reset write returns to idle
// - Drive kind read-only, loaded locally
// - Select write when idle starts command
// - Select write while busy is ignored
// - Enable port: drive, interrupt, DMA bits
module lhpi_top (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic host_dack_n,            // DMA acknowledge pin
    input wire logic primary_host_select_n,  // Primary chip select pin
    input wire logic host_ior_n,             // I/O read strobe pin
    input wire logic host_iow_n,             // I/O write strobe pin
    input wire logic host_addr_bit_one,
    input wire logic host_addr_bit_zero,
    input wire logic [7:0] host_data_in,     // Host write data
    output logic [7:0] host_data_out,        // Host read data
    output logic host_data_oe_n,             // Low while driving read data
    output logic host_dma_request,           // DMA request to host
    output logic host_interrupt_line,        // Interrupt to host
    input wire logic host_bus_flavor_select, // Local register 58H bit 7
    input wire logic drive_kind_we,          // Local write of drive kind
    input wire logic [7:0] drive_kind_wdata,
    input wire lhpi_pkg::lhpi_seq_s seq,     // Local sequencing
    output logic [7:0] host_write_byte,      // Last byte written by host to the data port
    output logic host_write_valid,           // One-cycle pulse per host data-port write
    output logic host_read_done,             // One-cycle pulse per data read of an offered byte
    output logic drive_choice,               // Drive select bit
    output logic [7:0] status_view           // Status byte for the local side
);
    ////////////////////////////////////////////////////////////////////////
    // State of the block
    typedef struct packed {
        logic busy;
        lhpi_pkg::lhpi_phase_e phase;
        logic req;
        logic completion;        // Status phase entered with interrupt enabled
        logic int_flag;
        logic dma_flag;
        logic [2:0] enables;
        logic [7:0] drive_kind;
        logic [7:0] rd_byte;
        logic [7:0] rd_out;
        logic rd_oe_n;
        logic rd_from_data;      // Open read cycle targets the data port
        logic [7:0] wr_byte;
        logic wr_valid;
        logic rd_done;
        logic ior_q;
        logic iow_q;
    } lhpi_state_s;
    lhpi_state_s st;
    lhpi_state_s next_st;
    lhpi_pkg::lhpi_host_s hs;
    logic [13:0] sync_q;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; strobes idle high
    lhpi_sync #(.W(14)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .d({host_dack_n, primary_host_select_n, host_ior_n, host_iow_n,
            host_addr_bit_one, host_addr_bit_zero, host_data_in}),
        .rst_val(14'h3fff),
        .q(sync_q)
    );
    assign hs = lhpi_pkg::lhpi_host_s'(sync_q);

    // Port decode shared by read and write
    function automatic logic [2:0] port_hit(input lhpi_pkg::lhpi_host_s h, input logic on);
        if (!on) begin
            port_hit = 3'h0;
        end else if (!h.dack_n) begin
            port_hit = {1'b1, lhpi_pkg::LHPI_PORT_DATA};
        end else if (!h.sel_n) begin
            port_hit = {1'b1, h.addr};
        end else begin
            port_hit = 3'h0;
        end
    endfunction

    logic [2:0] hit;
    logic rd_start;
    logic wr_start;
    logic rd_end;
    logic in_data;
    logic [7:0] status_byte;

    assign hit = port_hit(hs, host_bus_flavor_select);
    assign rd_start = st.ior_q && !hs.ior_n && hit[2];
    assign rd_end = !st.ior_q && hs.ior_n;
    assign wr_start = st.iow_q && !hs.iow_n && hit[2];
    assign in_data = st.busy && (st.phase == lhpi_pkg::LHPI_PH_DATA_IN
                                 || st.phase == lhpi_pkg::LHPI_PH_DATA_OUT);

    // Status byte; top bits zero
    always_comb begin
        status_byte = 8'h00;
        status_byte[lhpi_pkg::LHPI_ST_INT] = st.int_flag;
        status_byte[lhpi_pkg::LHPI_ST_DMA] = st.dma_flag;
        status_byte[lhpi_pkg::LHPI_ST_BUSY] = st.busy;
        status_byte[lhpi_pkg::LHPI_ST_CD] = st.busy & st.phase[1];
        status_byte[lhpi_pkg::LHPI_ST_DIR] = st.busy & st.phase[0];
        status_byte[lhpi_pkg::LHPI_ST_REQ] = st.req;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_st = st;
        next_st.ior_q = hs.ior_n;
        next_st.iow_q = hs.iow_n;
        next_st.wr_valid = 1'b0;
        next_st.rd_done = 1'b0;
        if (drive_kind_we) begin
            next_st.drive_kind = drive_kind_wdata;
        end
        // Local sequencing while busy
        if (st.busy && seq.set_phase) begin
            next_st.phase = seq.phase;
            // arm only if enable was set beforehand
            next_st.completion = (seq.phase == lhpi_pkg::LHPI_PH_STATUS)
                                 && st.enables[lhpi_pkg::LHPI_EN_INT];
        end
        if (st.busy && seq.byte_valid && !st.req) begin
            next_st.req = 1'b1;
            next_st.rd_byte = seq.byte_data;
        end
        // Read cycle: drive the selected port
        if (rd_start) begin
            next_st.rd_oe_n = 1'b0;
            next_st.rd_from_data = (hit[1:0] == lhpi_pkg::LHPI_PORT_DATA);
            unique case (hit[1:0])
                lhpi_pkg::LHPI_PORT_DATA: next_st.rd_out = st.rd_byte;
                lhpi_pkg::LHPI_PORT_STATUS: next_st.rd_out = status_byte;
                lhpi_pkg::LHPI_PORT_DRIVE: next_st.rd_out = st.drive_kind;
                lhpi_pkg::LHPI_PORT_ENABLE: next_st.rd_out = 8'h00;
            endcase
        end
        if (rd_end && !st.rd_oe_n) begin
            next_st.rd_oe_n = 1'b1;
            // Only a data-port read consumes the offered byte
            if (st.rd_from_data && st.req) begin
                next_st.req = 1'b0;
                next_st.rd_done = 1'b1;
            end
        end
        // Write cycle decode
        if (wr_start) begin
            unique case (hit[1:0])
                lhpi_pkg::LHPI_PORT_DATA: begin
                    next_st.wr_byte = hs.wdata;
                    next_st.wr_valid = 1'b1;
                    next_st.req = 1'b0;
                end
                lhpi_pkg::LHPI_PORT_STATUS: begin
                    next_st.busy = 1'b0;
                    next_st.req = 1'b0;
                    next_st.completion = 1'b0;
                    next_st.phase = lhpi_pkg::LHPI_PH_DATA_IN;
                end
                lhpi_pkg::LHPI_PORT_DRIVE: begin
                    if (!st.busy) begin
                        next_st.busy = 1'b1;
                        next_st.phase = lhpi_pkg::LHPI_PH_COMMAND;
                        next_st.completion = 1'b0;
                    end
                end
                lhpi_pkg::LHPI_PORT_ENABLE: begin
                    next_st.enables = hs.wdata[2:0];
                end
            endcase
        end
        if (st.busy && seq.finish) begin
            next_st.busy = 1'b0;
            next_st.req = 1'b0;
            next_st.completion = 1'b0;
        end
        if (!next_st.enables[lhpi_pkg::LHPI_EN_INT]) begin
            next_st.int_flag = 1'b0;
        end else if (st.completion && st.enables[lhpi_pkg::LHPI_EN_INT]) begin
            next_st.int_flag = 1'b1;
        end
        next_st.dma_flag = next_st.req && next_st.busy && !next_st.phase[1]
                           && next_st.enables[lhpi_pkg::LHPI_EN_DMA] && hs.dack_n;
        if (!hs.dack_n) begin
            next_st.dma_flag = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st <= '0;
            st.rd_oe_n <= 1'b1;
            st.ior_q <= 1'b1;
            st.iow_q <= 1'b1;
            st.enables <= lhpi_pkg::LHPI_RST_EN;
            st.drive_kind <= lhpi_pkg::LHPI_RST_BYTE;
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign host_data_out = st.rd_out;
    assign host_data_oe_n = st.rd_oe_n;
    assign host_dma_request = st.dma_flag;
    assign host_interrupt_line = st.int_flag;
    assign host_write_byte = st.wr_byte;
    assign host_write_valid = st.wr_valid;
    assign host_read_done = st.rd_done;
    assign drive_choice = st.enables[lhpi_pkg::LHPI_EN_DRV];
    assign status_view = status_byte;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_top_zero;
        @(posedge clock) disable iff (!rst_n) status_byte[7:6] == 2'h0;
    endproperty
    a_top_zero: assert property (p_top_zero) else $error("status top bits set");

    property p_int_needs_en;
        @(posedge clock) disable iff (!rst_n)
            st.int_flag |-> st.enables[lhpi_pkg::LHPI_EN_INT];
    endproperty
    a_int_needs_en: assert property (p_int_needs_en) else $error("interrupt without enable");

    property p_int_set;
        @(posedge clock) disable iff (!rst_n)
            (st.completion && st.enables[1] && next_st.enables[1]) |=> st.int_flag;
    endproperty
    a_int_set: assert property (p_int_set) else $error("interrupt not raised");

    property p_dma_cond;
        @(posedge clock) disable iff (!rst_n)
            st.dma_flag |-> (in_data && st.req && st.enables[lhpi_pkg::LHPI_EN_DMA]);
    endproperty
    a_dma_cond: assert property (p_dma_cond) else $error("dma request out of data phase");

    property p_dma_ack;
        @(posedge clock) disable iff (!rst_n) !hs.dack_n |=> !st.dma_flag;
    endproperty
    a_dma_ack: assert property (p_dma_ack) else $error("dma request held over ack");

    property p_start;
        @(posedge clock) disable iff (!rst_n)
            (wr_start && hit[1:0] == 2'h2 && !st.busy && !seq.finish)
            |=> (st.busy && st.phase == lhpi_pkg::LHPI_PH_COMMAND);
    endproperty
    a_start: assert property (p_start) else $error("select did not start");

    property p_ignore;
        @(posedge clock) disable iff (!rst_n)
            (wr_start && hit[1:0] == 2'h2 && st.busy && !seq.set_phase && !seq.finish)
            |=> $stable(st.phase) && st.busy;
    endproperty
    a_ignore: assert property (p_ignore) else $error("busy select changed state");

    property p_soft_reset;
        @(posedge clock) disable iff (!rst_n)
            (wr_start && hit[1:0] == 2'h1) |=> (!st.busy && !st.req && !st.dma_flag);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset not idle");

    property p_idle_phase;
        @(posedge clock) disable iff (!rst_n)
            !st.busy |-> status_byte[2:1] == 2'h0;
    endproperty
    a_idle_phase: assert property (p_idle_phase) else $error("phase bits while idle");

    property p_flavor;
        @(posedge clock) disable iff (!rst_n)
            !host_bus_flavor_select |-> hit == 3'h0;
    endproperty
    a_flavor: assert property (p_flavor) else $error("port hit with flavor off");
endmodule

// ### test/lhpi_host_model.sv
/*
 * Behavioural host processor on the I/O channel: one strobe cycle per call.
 * Assumes the device clock is given and that strobes are sampled by it.
 */
`timescale 1ns/100ps
module lhpi_host_model (
    input wire logic clock,
    output logic dack_n,
    output logic sel_n,
    output logic ior_n,
    output logic iow_n,
    output logic addr_one,
    output logic addr_zero,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic oe_n
);
    ////////////////////////////////////////////////////////////////////////
    // Idle bus: strobes high, data bus not held at a stale value
    initial begin
        {dack_n, sel_n, ior_n, iow_n, addr_one, addr_zero} = 6'h3c;
        wdata = 8'h5a;
    end

    // One host cycle: strobe low five clocks, high four clocks
    // acknowledge whenever dma is set, in any phase; it takes away the request
    task xfer(input logic rd_op, input logic dma, input logic [1:0] a,
              input logic [7:0] wd, output logic [7:0] rd, output logic drove);
        begin
            @(posedge clock);
            dack_n <= ~dma;
            sel_n <= dma;
            {addr_one, addr_zero} <= a;
            wdata <= wd;
            ior_n <= ~rd_op;
            iow_n <= rd_op;
            repeat (5) @(posedge clock);
            rd = rdata;
            drove = ~oe_n;
            // Released strobes go high; write data shows the inverse of its last value
            {dack_n, sel_n, ior_n, iow_n} <= 4'hf;
            wdata <= ~wd;
            repeat (4) @(posedge clock);
        end
    endtask
endmodule

// ### test/lhpi_tb.sv
/*
 * Self-checking bench for the host port block, host model on the far side.
 * Assumes the flavor bit and the local sequencing are driven from here.
 */
`timescale 1ns/100ps
module lhpi_tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic dack_n, sel_n, ior_n, iow_n, a1, a0, oe_n, dreq, irq, drv;
    logic flavor = 1'b1;
    logic dk_we = 1'b0;
    logic [7:0] dk_wdata = 8'h00;
    logic [7:0] wdata, rdata, wbyte, st_view;
    logic wvalid, rdone;
    lhpi_pkg::lhpi_seq_s seq = '0;
    int mismatches = 0;
    int n_tests = 0;
    int n_done = 0;
    int n_wr = 0;

    always #2.5 clock = ~clock;

    lhpi_host_model u_host (.clock(clock), .dack_n(dack_n), .sel_n(sel_n), .ior_n(ior_n),
        .iow_n(iow_n), .addr_one(a1), .addr_zero(a0), .wdata(wdata), .rdata(rdata),
        .oe_n(oe_n));

    lhpi_top u_dut (.clock(clock), .rst_n(rst_n), .host_dack_n(dack_n),
        .primary_host_select_n(sel_n), .host_ior_n(ior_n), .host_iow_n(iow_n),
        .host_addr_bit_one(a1), .host_addr_bit_zero(a0), .host_data_in(wdata),
        .host_data_out(rdata), .host_data_oe_n(oe_n), .host_dma_request(dreq),
        .host_interrupt_line(irq), .host_bus_flavor_select(flavor),
        .drive_kind_we(dk_we), .drive_kind_wdata(dk_wdata), .seq(seq),
        .host_write_byte(wbyte), .host_write_valid(wvalid), .host_read_done(rdone),
        .drive_choice(drv), .status_view(st_view));

    // Count completed data reads and data writes
    always @(posedge clock) begin
        if (rdone === 1'b1) begin
            n_done <= n_done + 1;
        end
        if (wvalid === 1'b1) begin
            n_wr <= n_wr + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task stop_test();
        begin
            $display("checks %0d, mismatches %0d", n_tests, mismatches);
            if (mismatches == 0 && n_tests > 0) begin
                $display("No errors found");
            end else begin
                $display("Errors were found");
            end
            $finish;
        end
    endtask

    // Compare one byte
    task chk(input logic [7:0] g, input logic [7:0] e, input string m);
        begin
            n_tests++;
            if (g !== e) begin
                mismatches++;
                $display("BAD %0t %s got %h want %h", $time, m, g, e);
            end
        end
    endtask

    // Bounded wait for interrupt (s=0) or DMA request (s=1) to reach a level
    task wt(input int s, input logic lv);
        int i;
        begin
            i = 0;
            while (((s == 0) ? irq : dreq) !== lv && i < 40) begin
                @(posedge clock);
                i++;
            end
            n_tests++;
            if (i == 40) begin
                mismatches++;
                $display("BAD %0t line %0d never reached %b", $time, s, lv);
                stop_test();
            end
        end
    endtask

    // Host write, and host read with comparison
    task wr(input logic [1:0] a, input logic [7:0] d);
        logic [7:0] x;
        logic o;
        u_host.xfer(1'b0, 1'b0, a, d, x, o);
    endtask

    task rchk(input logic dma, input logic [1:0] a, input logic [7:0] e, input string m);
        logic [7:0] x;
        logic o;
        begin
            u_host.xfer(1'b1, dma, a, 8'h00, x, o);
            chk(x, e, m);
        end
    endtask

    // Local sequencer loads a phase and offers a byte when v is set
    task ph(input lhpi_pkg::lhpi_phase_e p, input logic v, input logic [7:0] b);
        begin
            @(posedge clock);
            seq.set_phase <= 1'b1;
            seq.phase <= p;
            seq.byte_valid <= v;
            seq.byte_data <= b;
            @(posedge clock);
            seq.set_phase <= 1'b0;
            seq.byte_valid <= 1'b0;
            repeat (2) @(posedge clock);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task t_idle();
        begin
            rchk(1'b0, lhpi_pkg::LHPI_PORT_STATUS, 8'h00, "idle status");
            @(posedge clock);
            dk_we <= 1'b1;
            dk_wdata <= 8'h5a;
            @(posedge clock);
            dk_we <= 1'b0;
            rchk(1'b0, lhpi_pkg::LHPI_PORT_DRIVE, 8'h5a, "drive kind");
            rchk(1'b0, lhpi_pkg::LHPI_PORT_ENABLE, 8'h00, "unused port");
            $display("test idle done");
        end
    endtask

    task t_cmd();
        int d;
        int w;
        begin
            wr(lhpi_pkg::LHPI_PORT_DRIVE, 8'h00);
            rchk(1'b0, lhpi_pkg::LHPI_PORT_STATUS, 8'h0c, "command phase");
            chk(st_view, 8'h0c, "status view");
            ph(lhpi_pkg::LHPI_PH_DATA_IN, 1'b1, 8'h00);
            wr(lhpi_pkg::LHPI_PORT_DRIVE, 8'h00);
            rchk(1'b0, lhpi_pkg::LHPI_PORT_STATUS, 8'h09, "busy select");
            w = n_wr;
            wr(lhpi_pkg::LHPI_PORT_DATA, 8'ha5);
            chk(wbyte, 8'ha5, "write byte");
            chk(8'(n_wr - w), 8'h01, "write pulse count");
            ph(lhpi_pkg::LHPI_PH_DATA_OUT, 1'b1, 8'h3c);
            rchk(1'b0, lhpi_pkg::LHPI_PORT_STATUS, 8'h0b, "data out");
            d = n_done;
            rchk(1'b0, lhpi_pkg::LHPI_PORT_DATA, 8'h3c, "data read");
            @(posedge clock);
            chk(8'(n_done - d), 8'h01, "read count");
            $display("test command done");
        end
    endtask

    task t_dma();
        logic [7:0] x;
        logic o;
        begin
            wr(lhpi_pkg::LHPI_PORT_ENABLE, 8'h01);
            ph(lhpi_pkg::LHPI_PH_DATA_OUT, 1'b1, 8'hc3);
            wt(1, 1'b1);
            rchk(1'b0, lhpi_pkg::LHPI_PORT_STATUS, 8'h1b, "dma status");
            rchk(1'b1, lhpi_pkg::LHPI_PORT_STATUS, 8'hc3, "dma read");
            u_host.xfer(1'b0, 1'b1, lhpi_pkg::LHPI_PORT_DRIVE, 8'h96, x, o);
            chk(wbyte, 8'h96, "dma write");
            wr(lhpi_pkg::LHPI_PORT_ENABLE, 8'h00);
            wt(1, 1'b0);
            $display("test dma done");
        end
    endtask

    task t_done();
        begin
            wr(lhpi_pkg::LHPI_PORT_ENABLE, 8'h06);
            chk({7'h00, drv}, 8'h01, "drive select");
            ph(lhpi_pkg::LHPI_PH_STATUS, 1'b1, 8'h5e);
            wt(0, 1'b1);
            rchk(1'b0, lhpi_pkg::LHPI_PORT_STATUS, 8'h2f, "completion");
            rchk(1'b0, lhpi_pkg::LHPI_PORT_DATA, 8'h5e, "completion byte");
            chk({7'h00, irq}, 8'h01, "interrupt held");
            wr(lhpi_pkg::LHPI_PORT_ENABLE, 8'h00);
            wt(0, 1'b0);
            @(posedge clock);
            seq.finish <= 1'b1;
            seq.byte_valid <= 1'b0;
            @(posedge clock);
            seq.finish <= 1'b0;
            rchk(1'b0, lhpi_pkg::LHPI_PORT_STATUS, 8'h00, "finished");
            $display("test completion done");
        end
    endtask

    task t_srst();
        begin
            wr(lhpi_pkg::LHPI_PORT_DRIVE, 8'h00);
            ph(lhpi_pkg::LHPI_PH_STATUS, 1'b1, 8'h11);
            repeat (10) @(posedge clock);
            chk({7'h00, irq}, 8'h00, "no enable no interrupt");
            wr(lhpi_pkg::LHPI_PORT_ENABLE, 8'h02);
            chk({7'h00, irq}, 8'h00, "late enable no interrupt");
            seq.byte_valid <= 1'b0;
            wr(lhpi_pkg::LHPI_PORT_STATUS, 8'hff);
            rchk(1'b0, lhpi_pkg::LHPI_PORT_STATUS, 8'h00, "soft reset");
            $display("test soft reset done");
        end
    endtask

    task t_flav();
        logic [7:0] x;
        logic o;
        begin
            @(posedge clock);
            flavor <= 1'b0;
            wr(lhpi_pkg::LHPI_PORT_DRIVE, 8'h00);
            u_host.xfer(1'b1, 1'b0, lhpi_pkg::LHPI_PORT_STATUS, 8'h00, x, o);
            chk({7'h00, o}, 8'h00, "flavor off drive");
            flavor <= 1'b1;
            rchk(1'b0, lhpi_pkg::LHPI_PORT_STATUS, 8'h00, "flavor off select");
            $display("test flavor done");
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence and hang guard
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        t_idle();
        t_cmd();
        t_dma();
        t_done();
        t_srst();
        t_flav();
        stop_test();
    end

    initial begin
        #200000;
        mismatches++;
        $display("BAD %0t run too long", $time);
        stop_test();
    end
endmodule
